/* File: testbench/rcu_pin_model.sv */
// External reset circuit model: drives the active-low reset pin low for a fixed time
`timescale 1ns/1ps

module rcu_pin_model #(
  parameter int unsigned HOLD = 6
) (
  input  wire logic clock,
  input  wire logic press,
  output logic      pin_n
);
  logic [7:0] cnt_q = 8'h00;

  always @(posedge clock) begin
    if (press)
      cnt_q <= 8'(HOLD);
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end

  // Released pin sits at its pull-up level
  assign pin_n = (cnt_q == 8'h00);
endmodule

/* File: testbench/rcu_top_asserts.sv */
// Port-level assertions of the reset and clock unit
`timescale 1ns/1ps

module rcu_top_asserts #(
  parameter int unsigned STRETCH_PERIODS = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ext_reset_pin_n,
  input wire logic halt_req,
  input wire logic wdg_enable,
  input wire logic wdg_end_count,
  input wire logic internal_clock_en,
  input wire logic core_clock_en,
  input wire logic osc_stopped,
  input wire logic held_internal_reset_n,
  input wire logic reset_out_port_bit_oe,
  input wire logic sys_reset_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Counts cycles of the held reset being low
  logic [16:0] low_q;
  always_ff @(posedge clock) begin
    if (rst || held_internal_reset_n)
      low_q <= 17'h0;
    else if (low_q != 17'h1ffff)
      low_q <= low_q + 17'h1;
  end

  wire in_run = sys_reset_n && held_internal_reset_n && !osc_stopped;

  sequence s_pin_fall;
    $fell(ext_reset_pin_n);
  endsequence
  sequence s_held_low;
    ##[1:6] !held_internal_reset_n;
  endsequence

  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_pin_reset: assert property (s_pin_fall |-> s_held_low)
    else $error("pin fall ignored");
  chk_wdg_reset: assert property (wdg_end_count && in_run |=> !held_internal_reset_n && !sys_reset_n)
    else $error("watchdog ignored");
  chk_stretch_len: assert property ($rose(held_internal_reset_n) |-> low_q >= STRETCH_PERIODS)
    else $error("stretch short");
  chk_sys_after: assert property ($rose(held_internal_reset_n) |-> !sys_reset_n [*8])
    else $error("true reset early");
  chk_held_sys: assert property (!held_internal_reset_n |-> !sys_reset_n)
    else $error("true reset before held");
  chk_port_drive: assert property ($fell(rst) |-> reset_out_port_bit_oe && !held_internal_reset_n)
    else $error("port not driven");
  chk_halt_wdg: assert property (halt_req && wdg_enable && in_run |=> !osc_stopped [*8])
    else $error("oscillator stopped");
  chk_stop_quiet: assert property (osc_stopped && $past(osc_stopped) && $past(osc_stopped, 2)
                                   |-> !internal_clock_en && !core_clock_en)
    else $error("clock while stopped");
endmodule

bind rcu_top rcu_top_asserts #(.STRETCH_PERIODS(STRETCH_PERIODS)) rcu_top_asserts_inst (
  .clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ext_reset_pin_n, .halt_req,
  .wdg_enable, .wdg_end_count, .internal_clock_en, .core_clock_en, .osc_stopped,
  .held_internal_reset_n, .reset_out_port_bit_oe, .sys_reset_n
);

/* File: testbench/rcu_top_tb.sv */
// Self-checking bench of the reset and clock unit
`timescale 1ns/1ps

module rcu_top_tb;
  typedef struct packed {
    logic       we;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } rcu_row_t;

  logic        clock, rst, cyc, stb, we, halt_req, wdg_enable, wdg_end_count, press;
  logic        ack, pin_n, int_en, core_en, stopped, held_n, oe, sys_n, irq;
  logic [11:0] adr;
  logic [31:0] wdat, rdat;
  logic [7:0]  r;
  int          n_errors, check_count, ni, nc;
  rcu_row_t    rows [7] = '{'{0, 12'h3ac, 8'h00, 8'he0}, '{0, 12'h3c0, 8'h00, 8'h00},
    '{0, 12'h3c8, 8'h00, 8'h08}, '{1, 12'h3c8, 8'hff, 8'h08}, '{1, 12'h3ac, 8'h04, 8'h04},
    '{1, 12'h404, 8'h0f, 8'h0f}, '{0, 12'h010, 8'h00, 8'h00}};
  logic [7:0]  modes [4] = '{8'h00, 8'h20, 8'h1c, 8'h2c};
  int          exp_i [4] = '{40, 20, 40, 20};
  int          exp_c [4] = '{40, 20, 5, 5};

  rcu_top #(.STRETCH_PERIODS(16)) rcu_top_inst (
    .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_reset_pin_n(pin_n), .halt_req(halt_req), .wdg_enable(wdg_enable),
    .wdg_end_count(wdg_end_count), .internal_clock_en(int_en), .core_clock_en(core_en),
    .osc_stopped(stopped), .held_internal_reset_n(held_n), .reset_out_port_bit_oe(oe),
    .sys_reset_n(sys_n), .irq(irq));
  rcu_pin_model rcu_pin_model_inst (.clock(clock), .press(press), .pin_n(pin_n));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic complete_run();
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t byte got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t bit got %b exp %b", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    repeat (20) begin
      @(posedge clock);
      if (ack === 1'b1) break;
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      complete_run();
    end
    @(posedge clock);
  endtask

  task automatic wait_run();
    repeat (3000) begin
      @(posedge clock);
      if (sys_n === 1'b1) return;
    end
    n_errors++;
    complete_run();
  endtask

  task automatic pulse_halt();
    halt_req <= 1'b1;
    @(posedge clock);
    halt_req <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  initial begin
    {rst, cyc, stb, we, halt_req, wdg_enable, wdg_end_count, press} = 8'h80;
    adr = 12'h0;
    wdat = 32'h0;
    n_errors = 0;
    check_count = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk1(held_n, 1'b0);
    chk1(oe, 1'b1);
    wait_run();
    foreach (rows[i]) begin
      if (rows[i].we) bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 8'h00);
      chk8(r, rows[i].e);
    end
    foreach (modes[k]) begin
      bus(1'b1, 12'h3ac, modes[k]);
      repeat (16) @(posedge clock);
      ni = 0;
      nc = 0;
      repeat (40) begin
        @(posedge clock);
        if (int_en === 1'b1) ni++;
        if (core_en === 1'b1) nc++;
      end
      chk8(8'(ni), 8'(exp_i[k]));
      chk8(8'(nc), 8'(exp_c[k]));
    end
    bus(1'b1, 12'h408, 8'h01);
    chk1(oe, 1'b0);
    wdg_end_count <= 1'b1;
    @(posedge clock);
    wdg_end_count <= 1'b0;
    @(posedge clock);
    chk1(held_n, 1'b0);
    wait_run();
    bus(1'b0, 12'h3c8, 8'h00);
    chk8(r, 8'h48);
    bus(1'b0, 12'h3ac, 8'h00);
    chk8(r, 8'he0);
    chk1(oe, 1'b1);
    chk1(irq, 1'b1);
    bus(1'b1, 12'h404, 8'h00);
    repeat (2) @(posedge clock);
    chk1(irq, 1'b0);
    bus(1'b1, 12'h404, 8'h0f);
    bus(1'b1, 12'h400, 8'h04);
    repeat (2) @(posedge clock);
    chk1(irq, 1'b0);
    bus(1'b1, 12'h3c0, 8'h08);
    pulse_halt();
    wait_run();
    bus(1'b0, 12'h3c8, 8'h00);
    chk8(r, 8'h28);
    bus(1'b0, 12'h3c0, 8'h00);
    chk8(r, 8'h00);
    wdg_enable <= 1'b1;
    pulse_halt();
    chk1(stopped, 1'b0);
    chk1(sys_n, 1'b1);
    wdg_enable <= 1'b0;
    pulse_halt();
    chk1(stopped, 1'b1);
    repeat (20) @(posedge clock);
    chk1(sys_n, 1'b1);
    press <= 1'b1;
    @(posedge clock);
    press <= 1'b0;
    repeat (8) @(posedge clock);
    chk1(sys_n, 1'b0);
    wait_run();
    chk1(stopped, 1'b0);
    bus(1'b0, 12'h3c8, 8'h00);
    chk8(r, 8'h08);
    complete_run();
  end
endmodule

/* File: verilog/rcu_pkg.sv */
// Types shared by the reset and clock unit modules
package rcu_pkg;

  // ----------------------------------------------------------------
  // Reset sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RCU_RUN     = 3'b000,
    RCU_PIN_LOW = 3'b001,
    RCU_STRETCH = 3'b010,
    RCU_RELEASE = 3'b011,
    RCU_HALTED  = 3'b100
  } rcu_phase_t;

  // ----------------------------------------------------------------
  // State of the pulse divider
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cnt_q;
    logic       en_q;
  } rcu_div_state_t;

  // ----------------------------------------------------------------
  // State of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  mode_q;
    logic [7:0]  ctl_q;
    logic [7:0]  cause_q;
    logic [3:0]  sts_q;
    logic [3:0]  msk_q;
    logic        port_rel_q;
    rcu_phase_t  phase_q;
    logic [15:0] cnt_q;
    logic        pin_s1_q;
    logic        pin_s2_q;
    logic        pin_s3_q;
    logic        ack_q;
    logic [7:0]  rdata_q;
    logic        irq_q;
    logic        held_n_q;
    logic        sys_n_q;
    logic        oe_q;
    logic        stopped_q;
  } rcu_state_t;

endpackage

/* File: verilog/rcu_pulse_div.sv */
// Enable-pulse divider: one output pulse every div+1 input pulses
`timescale 1ns/1ps

module rcu_pulse_div (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       en_in,
  input  wire logic [2:0] div,
  output logic            en_out
);
  import rcu_pkg::*;

  rcu_div_state_t q;
  rcu_div_state_t d;

  always_comb begin
    d = q;
    d.en_q = 1'b0;
    if (en_in) begin
      if (q.cnt_q >= div) begin
        d.cnt_q = 3'h0;
        d.en_q  = 1'b1;
      end else begin
        d.cnt_q = q.cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign en_out = q.en_q;

endmodule

/* File: verilog/rcu_regs.svh */
// Register map, field positions, reset values and counts of the reset and clock unit
`ifndef RCU_REGS_SVH
`define RCU_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RCU_IDX_CLOCK_MODE    10'h0eb
`define RCU_IDX_CLOCK_CONTROL 10'h0f0
`define RCU_IDX_RESET_CAUSE   10'h0f2
`define RCU_IDX_IRQ_STATUS    10'h100
`define RCU_IDX_IRQ_MASK      10'h101
`define RCU_IDX_PORT_CONTROL  10'h102

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RCU_BIT_OSC_HALF      5
`define RCU_MSB_PRESCALE      4
`define RCU_LSB_PRESCALE      2
`define RCU_BIT_HALT_RST_EN   3
`define RCU_BIT_PORT_RELEASE  0
`define RCU_EV_EXT            0
`define RCU_EV_SOFT           1
`define RCU_EV_WDG            2
`define RCU_EV_HALT_STOP      3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RCU_RST_CLOCK_MODE    8'he0
`define RCU_RST_CLOCK_CONTROL 8'h00
`define RCU_CAUSE_WDG         8'h48
`define RCU_CAUSE_SOFT        8'h28
`define RCU_CAUSE_POWER_ON    8'h08
`define RCU_RST_IRQ           4'h0

// ----------------------------------------------------------------
// Reset timing: stretch in clock periods, release in internal_clock_en pulses
// ----------------------------------------------------------------
`define RCU_STRETCH_PERIODS   32768
`define RCU_RELEASE_PERIODS   9'h1ff

`endif

/* File: verilog/rcu_top.sv */
// Reset and clock control unit: clock dividers, halt handling, reset stretch and cause flags
//
// What this block does
// - A set osc_half_select bit halves the crystal clock; a clear bit passes it undivided.
// - A zero core_clock_prescale gives core_clock equal to internal_clock_pre, else divided by field plus one.
// - Reset loads clock_mode_reg with e0, so osc_half_select starts at one and core_clock_prescale at zero.
// - With halt_reset_enable clear and the watchdog disabled halt stops the oscillator and clocks; with halt_reset_enable set halt resets the device.
// - watchdog_reset_flag reads one only when the last reset came from watchdog end of count.
// - halt_reset_flag reads one only when the last reset was a software reset from halt.
// - After reset reset_cause_reg holds 48 for watchdog, 28 for software and 08 for power-on reset.
// - With the watchdog disabled and halt_reset_enable clear halt stops all clocks until a main system reset.
// - With the watchdog enabled and halt_reset_enable clear halt leaves the oscillator running, awaiting watchdog or pin reset.
// - A reset starts on a pin falling edge, on halt with software reset enabled, or on watchdog end of count.
// - held_internal_reset stays active for 32768 crystal periods after the reset pin returns high.
// - held_internal_reset is driven active low on reset_out_port_bit until software reconfigures it.
// - The true internal reset releases 511 reference clock periods after held_internal_reset.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rcu_regs.svh"

module rcu_top #(
  parameter int unsigned STRETCH_PERIODS = `RCU_STRETCH_PERIODS
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        halt_req,
  input  wire logic        wdg_enable,
  input  wire logic        wdg_end_count,
  output logic             internal_clock_en,
  output logic             core_clock_en,
  output logic             osc_stopped,
  output logic             held_internal_reset_n,
  output logic             reset_out_port_bit_oe,
  output logic             sys_reset_n,
  output logic             irq
);
  import rcu_pkg::*;

  rcu_state_t q;
  rcu_state_t d;

  logic       int_en;
  logic       core_en;
  logic       clk_run;
  logic [2:0] half_div;
  logic [2:0] pre_div;
  logic [9:0] idx;
  logic       bus_req;
  logic       bus_wr;
  logic       ext_fall;
  logic       start;
  logic [7:0] start_cause;
  logic [3:0] ev;

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  assign clk_run  = ~q.stopped_q;
  assign half_div = {2'b00, q.mode_q[`RCU_BIT_OSC_HALF]};
  assign pre_div  = q.mode_q[`RCU_MSB_PRESCALE:`RCU_LSB_PRESCALE];

  rcu_pulse_div u_half_div (
    .clock  (clock),
    .rst    (rst),
    .en_in  (clk_run),
    .div    (half_div),
    .en_out (int_en)
  );

  rcu_pulse_div u_prescale (
    .clock  (clock),
    .rst    (rst),
    .en_in  (int_en),
    .div    (pre_div),
    .en_out (core_en)
  );

  assign internal_clock_en = int_en;
  assign core_clock_en     = core_en;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign idx     = wb_adr_i[11:2];
  assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack_q;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];

  always_comb begin
    d           = q;
    start       = 1'b0;
    start_cause = `RCU_CAUSE_POWER_ON;
    ev          = 4'h0;

    // Two-stage synchroniser, third stage only for edge detection
    d.pin_s1_q = ext_reset_pin_n;
    d.pin_s2_q = q.pin_s1_q;
    d.pin_s3_q = q.pin_s2_q;
    ext_fall   = q.pin_s3_q & ~q.pin_s2_q;

    // Bus slave: one wait cycle, ack for one cycle
    d.ack_q = bus_req;
    if (bus_req) begin
      case (idx)
        `RCU_IDX_CLOCK_MODE:    d.rdata_q = q.mode_q;
        `RCU_IDX_CLOCK_CONTROL: d.rdata_q = q.ctl_q;
        `RCU_IDX_RESET_CAUSE:   d.rdata_q = q.cause_q;
        `RCU_IDX_IRQ_STATUS:    d.rdata_q = {4'h0, q.sts_q};
        `RCU_IDX_IRQ_MASK:      d.rdata_q = {4'h0, q.msk_q};
        `RCU_IDX_PORT_CONTROL:  d.rdata_q = {7'h00, q.port_rel_q};
        default:                d.rdata_q = 8'h00;
      endcase
    end
    if (bus_wr) begin
      case (idx)
        `RCU_IDX_CLOCK_MODE:    d.mode_q = wb_dat_i[7:0];
        `RCU_IDX_CLOCK_CONTROL: d.ctl_q  = wb_dat_i[7:0];
        `RCU_IDX_IRQ_STATUS:    d.sts_q  = q.sts_q & ~wb_dat_i[3:0];
        `RCU_IDX_IRQ_MASK:      d.msk_q  = wb_dat_i[3:0];
        `RCU_IDX_PORT_CONTROL:  d.port_rel_q = wb_dat_i[`RCU_BIT_PORT_RELEASE];
        default:                d.rdata_q = q.rdata_q;
      endcase
    end

    // Reset and halt sequencing
    case (q.phase_q)
      RCU_RUN: begin
        if (ext_fall) begin
          start       = 1'b1;
          start_cause = `RCU_CAUSE_POWER_ON;
          ev[`RCU_EV_EXT] = 1'b1;
        end else if (wdg_end_count) begin
          start       = 1'b1;
          start_cause = `RCU_CAUSE_WDG;
          ev[`RCU_EV_WDG] = 1'b1;
        end else if (halt_req && q.ctl_q[`RCU_BIT_HALT_RST_EN]) begin
          start       = 1'b1;
          start_cause = `RCU_CAUSE_SOFT;
          ev[`RCU_EV_SOFT] = 1'b1;
        end else if (halt_req && !wdg_enable) begin
          d.phase_q = RCU_HALTED;
          ev[`RCU_EV_HALT_STOP] = 1'b1;
        end
        // Halt with the watchdog running keeps the oscillator going
      end
      RCU_PIN_LOW: begin
        if (q.pin_s2_q) begin
          d.phase_q = RCU_STRETCH;
          d.cnt_q   = 16'h0000;
        end
      end
      RCU_STRETCH: begin
        if (ext_fall) begin
          start = 1'b1;
          ev[`RCU_EV_EXT] = 1'b1;
        end else if (q.cnt_q == 16'(STRETCH_PERIODS - 1)) begin
          d.phase_q = RCU_RELEASE;
          d.cnt_q   = 16'h0000;
        end else begin
          d.cnt_q = q.cnt_q + 16'h0001;
        end
      end
      RCU_RELEASE: begin
        if (ext_fall) begin
          start = 1'b1;
          ev[`RCU_EV_EXT] = 1'b1;
        end else if (int_en) begin
          if (q.cnt_q[8:0] == `RCU_RELEASE_PERIODS - 9'h001) begin
            d.phase_q = RCU_RUN;
          end
          d.cnt_q = q.cnt_q + 16'h0001;
        end
      end
      RCU_HALTED: begin
        // Only a main reset from the pin wakes the device
        if (ext_fall) begin
          start = 1'b1;
          ev[`RCU_EV_EXT] = 1'b1;
        end
      end
      default: begin
        d.phase_q = RCU_RUN;
      end
    endcase

    if (start) begin
      d.mode_q     = `RCU_RST_CLOCK_MODE;
      d.ctl_q      = `RCU_RST_CLOCK_CONTROL;
      d.cause_q    = start_cause;
      d.port_rel_q = 1'b0;
      d.cnt_q      = 16'h0000;
      d.phase_q    = ev[`RCU_EV_EXT] ? RCU_PIN_LOW : RCU_STRETCH;
    end

    // Sticky status: a new event wins over a clear in the same cycle
    d.sts_q = d.sts_q | ev;
    d.irq_q = |(d.sts_q & d.msk_q);

    d.stopped_q = (d.phase_q == RCU_HALTED);
    d.held_n_q  = (d.phase_q == RCU_RUN) || (d.phase_q == RCU_RELEASE) ||
                  (d.phase_q == RCU_HALTED);
    d.sys_n_q   = (d.phase_q == RCU_RUN) || (d.phase_q == RCU_HALTED);
    d.oe_q      = ~d.port_rel_q;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      q            <= '0;
      q.mode_q     <= `RCU_RST_CLOCK_MODE;
      q.ctl_q      <= `RCU_RST_CLOCK_CONTROL;
      q.cause_q    <= `RCU_CAUSE_POWER_ON;
      q.sts_q      <= `RCU_RST_IRQ;
      q.msk_q      <= `RCU_RST_IRQ;
      q.phase_q    <= RCU_STRETCH;
      q.pin_s1_q   <= 1'b1;
      q.pin_s2_q   <= 1'b1;
      q.pin_s3_q   <= 1'b1;
      q.oe_q       <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o              = {24'h000000, q.rdata_q};
  assign wb_ack_o              = q.ack_q;
  assign osc_stopped           = q.stopped_q;
  assign held_internal_reset_n = q.held_n_q;
  assign reset_out_port_bit_oe = q.oe_q;
  assign sys_reset_n           = q.sys_n_q;
  assign irq                   = q.irq_q;

endmodule
